// ===== verilog/tof_regs_defines.vh
// Offsets, field positions, reset values and limits of the register slice.
// Assumes an 8-bit register port with byte addresses.
`ifndef TOF_REGS_DEFINES_VH
`define TOF_REGS_DEFINES_VH

`define ADDR_TEMP_TL0 8'h60
`define ADDR_TEMP_TL1 8'h61
`define ADDR_TEMP_TR0 8'h62
`define ADDR_TEMP_TR1 8'h63
`define ADDR_TEMP_BL0 8'h64
`define ADDR_TEMP_BL1 8'h65
`define ADDR_TEMP_BR0 8'h66
`define ADDR_TEMP_BR1 8'h67
`define ADDR_FINE0 8'h71
`define ADDR_FINE1 8'h72
`define ADDR_COARSE 8'h73
`define ADDR_MODE 8'h7d
`define ADDR_CLKCTL 8'h80
`define ADDR_DLY_EN 8'hae

`define RST_FINE0 8'h00
`define RST_FINE1 8'h00
`define RST_COARSE 8'h00
`define RST_MODE 8'h04
`define RST_CLKCTL 8'h3f
`define RST_DLY_EN 8'h00

`define BIT_PLL_EN 2
`define BIT_CLK_SRC 6
`define BIT_DLY_EN 2

`define MODE_WMASK 8'h04
`define CLKCTL_WMASK 8'h40
`define DLY_EN_WMASK 8'h04

`define FINE_MAX 10'h31f
`define COARSE_MAX 6'h31
`define FINE_STEP_PS 20'h0000a
`define COARSE_STEP_PS 20'h007d0

`define TEMP_SAMPLE_LAST 2'h3
`define TEMP_ROW_LAST 2'h3

`endif

// ===== verilog/temp_accum.v
// One corner temperature accumulator: sums consecutive sensor readings.
// Assumes i_sample marks a valid 12-bit reading on i_reading.
`timescale 1ns/1ps
`include "tof_regs_defines.vh"

module temp_accum (
    input wire i_sys_clk,
    input wire i_srst,
    input wire i_sample,
    input wire [11:0] i_reading,
    output reg [15:0] o_sum
);

    reg [15:0] acc;
    reg [1:0] cnt;

    always @(posedge i_sys_clk) begin
        if (i_srst) begin
            acc <= 16'h0000;
            cnt <= 2'h0;
            o_sum <= 16'h0000;
        end else if (i_sample) begin
            cnt <= cnt + 2'h1;
            if (cnt == `TEMP_SAMPLE_LAST) begin
                o_sum <= acc + {4'h0, i_reading}; // R1
                acc <= 16'h0000;
            end else begin
                acc <= acc + {4'h0, i_reading}; // R1
            end
        end
    end

endmodule

// ===== verilog/tof_clock_delay_temp_regs.v
// Register slice: corner temperatures, LED delay, PLL and clock source.
// Assumes a host register port in the system clock domain and a row
// readout strobe plus four sensor readings from the pixel sequencer.
`timescale 1ns/1ps
`include "tof_regs_defines.vh"

// Operation
// R1: Each corner temperature reads as sum of four readings, every fourth row.
// R2: Fine LED delay in steps of about 10 ps, limited to 799.
// R3: Fine delay applies only while delay-enable bit 2 is set.
// R4: Coarse LED delay in steps of about 2 ns, limited to 0x31.
// R5: Coarse delay applies only while delay-enable bit 2 is set.
// R6: Mode control bit 2 runs the PLL; resets to 0x04.
// R7: Clock control bit 6 selects external modulation clock; defaults 0.
// R8: Fine count is one 10-bit value over two bytes, combined with coarse.
module tof_clock_delay_temp_regs (
    input wire i_sys_clk,
    input wire i_srst,
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [7:0] o_rdata,
    input wire i_row_done,
    input wire [11:0] i_temp_tl,
    input wire [11:0] i_temp_tr,
    input wire [11:0] i_temp_bl,
    input wire [11:0] i_temp_br,
    output reg [9:0] o_fine_steps,
    output reg [5:0] o_coarse_steps,
    output reg [19:0] o_led_delay_ps,
    output reg o_pll_enable,
    output reg o_ext_external_modulation_clock_input_sel
);

    reg [7:0] fine0;
    reg [7:0] fine1;
    reg [7:0] coarse;
    reg [7:0] mode_ctl;
    reg [7:0] clk_ctl;
    reg [7:0] dly_en;
    reg [1:0] row_cnt;
    reg sample;
    reg [7:0] next_rdata;

    wire [11:0] readings [0:3];
    wire [15:0] sums [0:3];
    wire [9:0] fine_raw;
    wire [9:0] fine_lim;
    wire [5:0] coarse_lim;
    wire dly_on;

    assign readings[0] = i_temp_tl;
    assign readings[1] = i_temp_tr;
    assign readings[2] = i_temp_bl;
    assign readings[3] = i_temp_br;

    // Take a reading on every fourth row readout
    always @(posedge i_sys_clk) begin
        if (i_srst) begin
            row_cnt <= 2'h0;
            sample <= 1'b0;
        end else begin
            sample <= 1'b0;
            if (i_row_done) begin
                row_cnt <= row_cnt + 2'h1;
                sample <= (row_cnt == `TEMP_ROW_LAST); // R1
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : corner
            temp_accum u_acc (
                .i_sys_clk(i_sys_clk),
                .i_srst(i_srst),
                .i_sample(sample),
                .i_reading(readings[g]),
                .o_sum(sums[g])
            );
        end
    endgenerate

    // Register writes; reserved bits keep their reset values
    always @(posedge i_sys_clk) begin
        if (i_srst) begin
            fine0 <= `RST_FINE0;
            fine1 <= `RST_FINE1;
            coarse <= `RST_COARSE;
            mode_ctl <= `RST_MODE; // R6
            clk_ctl <= `RST_CLKCTL; // R7
            dly_en <= `RST_DLY_EN;
        end else if (i_wr) begin
            case (i_addr)
                `ADDR_FINE0: fine0 <= i_wdata;
                `ADDR_FINE1: fine1 <= {6'h00, i_wdata[1:0]}; // R8
                `ADDR_COARSE: coarse <= i_wdata;
                `ADDR_MODE: mode_ctl <= (`RST_MODE & ~`MODE_WMASK) |
                    (i_wdata & `MODE_WMASK);
                `ADDR_CLKCTL: clk_ctl <= (`RST_CLKCTL & ~`CLKCTL_WMASK) |
                    (i_wdata & `CLKCTL_WMASK);
                `ADDR_DLY_EN: dly_en <= i_wdata & `DLY_EN_WMASK;
                default: begin
                end
            endcase
        end
    end

    // Fine value stored little-endian: low byte at the lower address
    assign fine_raw = {fine1[1:0], fine0}; // R8
    // Out-of-range settings saturate rather than wrap
    assign fine_lim = (fine_raw > `FINE_MAX) ? `FINE_MAX : fine_raw; // R2
    assign coarse_lim = (coarse > {2'h0, `COARSE_MAX}) ? `COARSE_MAX :
        coarse[5:0]; // R4
    assign dly_on = dly_en[`BIT_DLY_EN];

    always @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_fine_steps <= 10'h000;
            o_coarse_steps <= 6'h00;
            o_led_delay_ps <= 20'h00000;
            o_pll_enable <= 1'b1;
            o_ext_external_modulation_clock_input_sel <= 1'b0;
        end else begin
            o_fine_steps <= dly_on ? fine_lim : 10'h000; // R3
            o_coarse_steps <= dly_on ? coarse_lim : 6'h00; // R5
            o_led_delay_ps <= dly_on ?
                (fine_lim * `FINE_STEP_PS + coarse_lim * `COARSE_STEP_PS)
                : 20'h00000; // R8
            o_pll_enable <= mode_ctl[`BIT_PLL_EN]; // R6
            o_ext_external_modulation_clock_input_sel <= clk_ctl[`BIT_CLK_SRC]; // R7
        end
    end

    always @* begin
        next_rdata = 8'h00;
        case (i_addr)
            `ADDR_TEMP_TL0: next_rdata = sums[0][15:8];
            `ADDR_TEMP_TL1: next_rdata = sums[0][7:0];
            `ADDR_TEMP_TR0: next_rdata = sums[1][15:8];
            `ADDR_TEMP_TR1: next_rdata = sums[1][7:0];
            `ADDR_TEMP_BL0: next_rdata = sums[2][15:8];
            `ADDR_TEMP_BL1: next_rdata = sums[2][7:0];
            `ADDR_TEMP_BR0: next_rdata = sums[3][15:8];
            `ADDR_TEMP_BR1: next_rdata = sums[3][7:0];
            `ADDR_FINE0: next_rdata = fine0;
            `ADDR_FINE1: next_rdata = fine1;
            `ADDR_COARSE: next_rdata = coarse;
            `ADDR_MODE: next_rdata = mode_ctl;
            `ADDR_CLKCTL: next_rdata = clk_ctl;
            `ADDR_DLY_EN: next_rdata = dly_en;
            default: next_rdata = 8'h00;
        endcase
    end

    // Read data valid only in the cycle after the read strobe
    always @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            o_rdata <= next_rdata; // R1
        end else begin
            o_rdata <= 8'h00;
        end
    end

endmodule

// ===== dv/tof_regs_checker_asserts.sv
// Assertions on the register slice ports.
// Assumes one clock and a sync active-high reset.
`timescale 1ns/1ps
module tof_regs_checker (
    input wire i_sys_clk, i_srst, i_wr, i_rd, o_pll_enable, o_ext_external_modulation_clock_input_sel,
    input wire [7:0] i_addr, i_wdata, o_rdata,
    input wire [9:0] o_fine_steps,
    input wire [5:0] o_coarse_steps,
    input wire [19:0] o_led_delay_ps
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);
    a_fine_max: assert property (o_fine_steps <= 10'h31f)
        else $error("fine over max");
    a_coarse_max: assert property (o_coarse_steps <= 6'h31)
        else $error("coarse over max");
    a_delay_sum: assert property (o_led_delay_ps ==
        o_fine_steps * 20'h0000a + o_coarse_steps * 20'h007d0)
        else $error("delay sum");
    a_pll_write: assert property (i_wr && i_addr == 8'h7d |->
        ##2 o_pll_enable == $past(i_wdata[2], 2)) else $error("pll");
    a_src_write: assert property (i_wr && i_addr == 8'h80 |->
        ##2 o_ext_external_modulation_clock_input_sel == $past(i_wdata[6], 2)) else $error("src");
    a_delay_gate: assert property (i_wr && i_addr == 8'hae &&
        !i_wdata[2] |-> ##2 o_led_delay_ps == 20'h00000) else $error("gate");
    a_reset_out: assert property ($past(i_srst) |->
        o_pll_enable && !o_ext_external_modulation_clock_input_sel) else $error("reset");
    a_mode_rsvd: assert property ($past(i_rd && i_addr == 8'h7d) |->
        (o_rdata & 8'hfb) == 8'h00) else $error("mode bits");
    cover property (i_wr && i_addr == 8'hae && i_wdata[2]);
    cover property (o_fine_steps == 10'h31f);
    cover property (o_ext_external_modulation_clock_input_sel);
endmodule
bind tof_clock_delay_temp_regs tof_regs_checker chk (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_pll_enable(o_pll_enable),
    .o_ext_external_modulation_clock_input_sel(o_ext_external_modulation_clock_input_sel),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .o_rdata(o_rdata),
    .o_fine_steps(o_fine_steps),
    .o_coarse_steps(o_coarse_steps),
    .o_led_delay_ps(o_led_delay_ps)
);

// ===== dv/host_model.sv
// Host stand-in: register port strobes, one cycle each.
// Assumes its tasks are called from one process of the bench.
`timescale 1ns/1ps
module host_model (
    input wire i_sys_clk,
    input wire [7:0] i_rdata,
    output reg [7:0] o_addr = 8'h00, o_wdata = 8'h00,
    output reg o_wr = 1'b0, o_rd = 1'b0
);
    task wr(input [7:0] a, input [7:0] d);
        @(posedge i_sys_clk) {o_addr, o_wdata, o_wr} <= {a, d, 1'b1};
        // Inverted data after the strobe exposes a late capture
        @(posedge i_sys_clk) {o_wdata, o_wr} <= {~d, 1'b0};
    endtask
    task rd(input [7:0] a, output [7:0] d);
        @(posedge i_sys_clk) {o_addr, o_rd} <= {a, 1'b1};
        @(posedge i_sys_clk) o_rd <= 1'b0;
        @(negedge i_sys_clk) d = i_rdata;
    endtask
endmodule

// ===== dv/tb_tof_clock_delay_temp_regs.sv
// Bench: host traffic, row pulses and corner readings that swap every 8 cycles.
// Assumes host_model drives the port and the checker is bound.
`timescale 1ns/1ps
module tb_tof_clock_delay_temp_regs;
    reg i_sys_clk = 1'b0, i_srst = 1'b1, i_row_done = 1'b0;
    wire [7:0] i_addr, i_wdata, o_rdata;
    wire i_wr, i_rd, o_pll_enable, o_ext_external_modulation_clock_input_sel;
    wire [9:0] o_fine_steps;
    wire [5:0] o_coarse_steps;
    wire [19:0] o_led_delay_ps;
    wire [1:0] pins = {o_pll_enable, o_ext_external_modulation_clock_input_sel};
    reg flip = 1'b0;
    reg [2:0] ph = 3'h0;
    // Readings swap every 8 cycles, so four samples taken 8 cycles
    // apart always hold two of each value, whatever the phase
    wire [11:0] i_temp_tl = flip ? 12'h321 : 12'h123;
    wire [11:0] i_temp_tr = flip ? 12'h654 : 12'h456;
    wire [11:0] i_temp_bl = flip ? 12'h987 : 12'h789;
    wire [11:0] i_temp_br = flip ? 12'hffd : 12'hfff;
    // Each corner sum is twice the sum of its two readings
    wire [63:0] exp_sum = {16'h3ff8, 16'h2220, 16'h1554, 16'h0888};
    reg [7:0] v, k;
    integer errors = 0, cmp_count = 0;
    tof_clock_delay_temp_regs dut (
        .i_sys_clk(i_sys_clk),
        .i_srst(i_srst),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_wr(i_wr),
        .i_rd(i_rd),
        .o_rdata(o_rdata),
        .i_row_done(i_row_done),
        .i_temp_tl(i_temp_tl),
        .i_temp_tr(i_temp_tr),
        .i_temp_bl(i_temp_bl),
        .i_temp_br(i_temp_br),
        .o_fine_steps(o_fine_steps),
        .o_coarse_steps(o_coarse_steps),
        .o_led_delay_ps(o_led_delay_ps),
        .o_pll_enable(o_pll_enable),
        .o_ext_external_modulation_clock_input_sel(o_ext_external_modulation_clock_input_sel)
    );
    always @(posedge i_sys_clk) begin
        ph <= ph + 3'h1;
        if (ph == 3'h7)
            flip <= ~flip;
    end
    host_model host (.i_sys_clk(i_sys_clk), .i_rdata(o_rdata),
        .o_addr(i_addr), .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd));
    always #5 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) i_row_done <= ~i_row_done & ~i_srst;
    task check(input [47:0] nm, input [19:0] seen, input [19:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("Error %0s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task rc(input [7:0] a, input [7:0] e);
        host.rd(a, v);
        check("rdata", {12'h000, v}, {12'h000, e});
    endtask
    task give_verdict(input integer extra);
        errors = errors + extra;
        $display("Compares %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial #20000 give_verdict(1);
    initial begin
        repeat (3) @(posedge i_sys_clk);
        i_srst <= 1'b0;
        rc(8'h7d, 8'h04);
        rc(8'h80, 8'h3f);
        rc(8'h60, 8'h00);
        check("pins", {18'h0, pins}, 20'h00002);
        check("fine", {10'h000, o_fine_steps}, 20'h00000);
        check("coarse", {14'h0000, o_coarse_steps}, 20'h00000);
        host.wr(8'h7d, 8'hf9);
        host.wr(8'h80, 8'hff);
        rc(8'h7d, 8'h00);
        rc(8'h80, 8'h7f);
        check("pins", {18'h0, pins}, 20'h00001);
        $display("reset and mode test done");
        host.wr(8'h71, 8'h3f);
        host.wr(8'h72, 8'hff);
        host.wr(8'h73, 8'hff);
        rc(8'h72, 8'h03);
        check("delay", o_led_delay_ps, 20'h00000);
        host.wr(8'hae, 8'h04);
        rc(8'hae, 8'h04);
        check("fine", {10'h000, o_fine_steps}, 20'h0031f);
        check("coarse", {14'h0000, o_coarse_steps}, 20'h00031);
        check("delay", o_led_delay_ps, 20'h19e06);
        host.wr(8'hae, 8'h00);
        rc(8'hae, 8'h00);
        check("fine", {10'h000, o_fine_steps}, 20'h00000);
        check("coarse", {14'h0000, o_coarse_steps}, 20'h00000);
        check("delay", o_led_delay_ps, 20'h00000);
        rc(8'h71, 8'h3f);
        $display("delay test done");
        host.wr(8'h60, 8'hff);
        // Let at least one full group of four samples complete
        repeat (40) @(posedge i_sys_clk);
        for (k = 8'h00; k < 8'h04; k = k + 8'h01) begin
            rc(8'h60 + (k << 1), exp_sum[k * 16 + 8 +: 8]);
            rc(8'h61 + (k << 1), exp_sum[k * 16 +: 8]);
        end
        $display("temperature test done");
        @(posedge i_sys_clk);
        i_srst <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        i_srst <= 1'b0;
        rc(8'h7d, 8'h04);
        rc(8'h72, 8'h00);
        rc(8'h60, 8'h00);
        check("pins", {18'h0, pins}, 20'h00002);
        $display("second reset test done");
        give_verdict(0);
    end
endmodule
